// ==== subsystem_ident_eeprom_loader.sv ====
// Loader of subsystem identity from a serial EEPROM, with the configuration read path for it.
`timescale 1ns/1ps
module subsystem_ident_eeprom_loader
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic cfgReq,
   input wire logic cfgWrite,
   input wire logic [1:0] cfgFunc,
   input wire logic [7:0] cfgOffset,
   output logic cfgDone,
   output logic cfgRetry,
   output logic cfgClaim,
   output logic [31:0] cfgReadData,
   output logic loadDone,
   output logic eepromAbsent,
   output logic configEepromClock,
   input wire logic configEepromSerialIn,
   output logic configEepromDataOut,
   output logic configEepromDataOe
);
   import ident_loader_pkg::*;

   // ----------------------------------------------------------------
   // Reset and input synchronisers
   // ----------------------------------------------------------------
   logic rstMeta_ff;
   logic rstN;
   logic sdaMeta_ff;
   logic sdaSync_ff;

   // Release of the reset is synchronised; assertion stays asynchronous.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rstMeta_ff <= 1'b0;
         rstN <= 1'b0;
      end
      else
      begin
         rstMeta_ff <= 1'b1;
         rstN <= rstMeta_ff;
      end
   end

   // Serial data comes from outside the clock domain.
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         sdaMeta_ff <= 1'b1;
         sdaSync_ff <= 1'b1;
      end
      else
      begin
         sdaMeta_ff <= configEepromSerialIn;
         sdaSync_ff <= sdaMeta_ff;
      end
   end

   // ----------------------------------------------------------------
   // Serial bit timing
   // ----------------------------------------------------------------
   load_state_t state_ff;
   logic [4:0] quarterCnt_ff;
   logic [1:0] phase_ff;
   logic serialActive;
   logic tick;
   logic sampleTick;
   logic slotEnd;

   assign serialActive = (state_ff != ST_DEFAULT) && (state_ff != ST_DONE);
   assign tick = serialActive && (quarterCnt_ff == QUARTER_LAST);
   assign sampleTick = tick && (phase_ff == 2'h2);
   assign slotEnd = tick && (phase_ff == 2'h3);

   // Each slot is four quarters: data set, clock rise, clock high with sample, clock fall.
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         quarterCnt_ff <= 5'h00;
         phase_ff <= 2'h0;
      end
      else if (tick)
      begin
         quarterCnt_ff <= 5'h00;
         phase_ff <= phase_ff + 2'h1;
      end
      else if (serialActive)
      begin
         quarterCnt_ff <= quarterCnt_ff + 5'h01;
      end
   end

   // ----------------------------------------------------------------
   // Load sequencer
   // ----------------------------------------------------------------
   logic [3:0] bitCnt_ff;
   logic [7:0] txByte_ff;
   logic ackOk_ff;
   logic absent_ff;
   logic [6:0] dataBitCnt_ff;
   logic [15:0] shift_ff;
   logic [2:0] defIdx_ff;
   logic inByte;

   assign inByte = (state_ff == ST_CTRLW) || (state_ff == ST_ADDR) || (state_ff == ST_CTRLR);

   // Random read of location 0 followed by a sequential read of twelve bytes.
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         state_ff <= ST_START1;
         bitCnt_ff <= 4'h0;
         txByte_ff <= EE_CTRL_WRITE;
         absent_ff <= 1'b0;
         defIdx_ff <= 3'h0;
      end
      else
      begin
         case (state_ff)
            ST_START1, ST_START2:
            begin
               if (slotEnd)
               begin
                  state_ff <= (state_ff == ST_START1) ? ST_CTRLW : ST_CTRLR;
                  txByte_ff <= (state_ff == ST_START1) ? EE_CTRL_WRITE : EE_CTRL_READ;
                  bitCnt_ff <= 4'h0;
               end
            end
            ST_CTRLW, ST_ADDR, ST_CTRLR:
            begin
               if (slotEnd && bitCnt_ff != ACK_SLOT)
               begin
                  txByte_ff <= {txByte_ff[6:0], 1'b0};
                  bitCnt_ff <= bitCnt_ff + 4'h1;
               end
               else if (slotEnd && !ackOk_ff)
               begin
                  absent_ff <= 1'b1;
                  state_ff <= ST_STOP;
               end
               else if (slotEnd)
               begin
                  bitCnt_ff <= 4'h0;
                  txByte_ff <= EE_START_ADDR;
                  case (state_ff)
                     ST_CTRLW: state_ff <= ST_ADDR;
                     ST_ADDR: state_ff <= ST_START2;
                     default: state_ff <= ST_READ;
                  endcase
               end
            end
            ST_READ:
            begin
               if (slotEnd && bitCnt_ff != ACK_SLOT)
               begin
                  bitCnt_ff <= bitCnt_ff + 4'h1;
               end
               else if (slotEnd)
               begin
                  bitCnt_ff <= 4'h0;
                  // Stop after bit 05Fh; the rest of the array is never clocked out.
                  if (dataBitCnt_ff == ID_BITS)
                  begin
                     state_ff <= ST_STOP;
                  end
               end
            end
            ST_STOP:
            begin
               if (slotEnd)
               begin
                  state_ff <= absent_ff ? ST_DEFAULT : ST_DONE;
               end
            end
            ST_DEFAULT:
            begin
               defIdx_ff <= defIdx_ff + 3'h1;
               if (defIdx_ff == WORD_LAST)
               begin
                  state_ff <= ST_DONE;
               end
            end
            default:
            begin
               state_ff <= ST_DONE;
            end
         endcase
      end
   end

   // Sample acknowledges and data at the end of the clock-high quarter.
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         ackOk_ff <= 1'b0;
         dataBitCnt_ff <= 7'h00;
         shift_ff <= 16'h0000;
      end
      else if (sampleTick && inByte && bitCnt_ff == ACK_SLOT)
      begin
         ackOk_ff <= !sdaSync_ff;
      end
      else if (sampleTick && state_ff == ST_READ && bitCnt_ff != ACK_SLOT)
      begin
         shift_ff <= {shift_ff[14:0], sdaSync_ff};
         dataBitCnt_ff <= dataBitCnt_ff + 7'h01;
      end
   end

   // ----------------------------------------------------------------
   // Line drive
   // ----------------------------------------------------------------
   logic nxt_scl;
   logic nxt_sdaLow;
   logic sclOut_ff;
   logic sdaLow_ff;

   // Data only changes while the clock is low, except the start and stop edges.
   always_comb
   begin
      nxt_scl = 1'b1;
      nxt_sdaLow = 1'b0;
      case (state_ff)
         ST_START1, ST_START2:
         begin
            nxt_scl = (phase_ff == 2'h1) || (phase_ff == 2'h2);
            nxt_sdaLow = phase_ff[1];
         end
         ST_CTRLW, ST_ADDR, ST_CTRLR:
         begin
            nxt_scl = (phase_ff == 2'h1) || (phase_ff == 2'h2);
            nxt_sdaLow = (bitCnt_ff != ACK_SLOT) && !txByte_ff[7];
         end
         ST_READ:
         begin
            nxt_scl = (phase_ff == 2'h1) || (phase_ff == 2'h2);
            nxt_sdaLow = (bitCnt_ff == ACK_SLOT) && (dataBitCnt_ff != ID_BITS);
         end
         ST_STOP:
         begin
            nxt_scl = (phase_ff != 2'h0);
            nxt_sdaLow = !phase_ff[1];
         end
         default:
         begin
            nxt_scl = 1'b1;
            nxt_sdaLow = 1'b0;
         end
      endcase
   end

   // Open-drain data: only ever pulled low, released for a one.
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         sclOut_ff <= 1'b1;
         sdaLow_ff <= 1'b0;
      end
      else
      begin
         sclOut_ff <= nxt_scl;
         sdaLow_ff <= nxt_sdaLow;
      end
   end

   assign configEepromClock = sclOut_ff;
   assign configEepromDataOut = 1'b0;
   assign configEepromDataOe = sdaLow_ff;

   // ----------------------------------------------------------------
   // Identity store writes
   // ----------------------------------------------------------------
   ident_store_if storeBus ();
   logic [15:0] defaultWord;

   // Common vendor default, one subsystem default per function.
   always_comb
   begin
      case (defIdx_ff)
         identIndex(FUNC_AUDIO, 1'b1): defaultWord = DEFAULT_SUBSYS_AUDIO;
         identIndex(FUNC_JOYSTICK, 1'b1): defaultWord = DEFAULT_SUBSYS_JOYSTICK;
         identIndex(FUNC_UART, 1'b1): defaultWord = DEFAULT_SUBSYS_UART;
         default: defaultWord = DEFAULT_VENDOR;
      endcase
   end

   // A word is complete on its sixteenth bit; the first bit has shifted up to bit 15.
   always_comb
   begin
      if (state_ff == ST_DEFAULT)
      begin
         storeBus.wrEn = 1'b1;
         storeBus.wrIndex = defIdx_ff;
         storeBus.wrData = defaultWord;
      end
      else
      begin
         storeBus.wrEn = sampleTick && state_ff == ST_READ && bitCnt_ff != ACK_SLOT
            && dataBitCnt_ff[3:0] == 4'hF;
         storeBus.wrIndex = dataBitCnt_ff[6:4];
         storeBus.wrData = {shift_ff[14:0], sdaSync_ff};
      end
   end

   assign storeBus.rdFunc = cfgFunc;

   ident_store store
   (
      .clk (clk),
      .rstN (rstN),
      .bus (storeBus)
   );

   // ----------------------------------------------------------------
   // Configuration read path
   // ----------------------------------------------------------------
   logic loaded_ff;
   logic p1Valid_ff;
   logic p1Write_ff;
   logic p1Claim_ff;
   logic p1Ident_ff;
   logic cfgDone_ff;
   logic cfgRetry_ff;
   logic cfgClaim_ff;
   logic [31:0] cfgReadData_ff;

   // Loaded stays set until reset; the last default or EEPROM word lands first.
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         loaded_ff <= 1'b0;
      end
      else if (state_ff == ST_DONE)
      begin
         loaded_ff <= 1'b1;
      end
   end

   // Stage one decodes while the store fetches the function's dword.
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         p1Valid_ff <= 1'b0;
         p1Write_ff <= 1'b0;
         p1Claim_ff <= 1'b0;
         p1Ident_ff <= 1'b0;
      end
      else
      begin
         p1Valid_ff <= cfgReq;
         p1Write_ff <= cfgWrite;
         p1Claim_ff <= (cfgFunc < FUNC_COUNT) && (cfgOffset <= CFG_HEADER_LAST);
         p1Ident_ff <= (cfgOffset[7:2] == CFG_SUBSYS_VENDOR_OFFSET[7:2]);
      end
   end

   // Stage two answers; writes complete without touching the identity words.
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         cfgDone_ff <= 1'b0;
         cfgRetry_ff <= 1'b0;
         cfgClaim_ff <= 1'b0;
         cfgReadData_ff <= 32'h0000_0000;
      end
      else
      begin
         cfgDone_ff <= p1Valid_ff;
         cfgClaim_ff <= p1Valid_ff && p1Claim_ff;
         cfgRetry_ff <= p1Valid_ff && p1Claim_ff && !loaded_ff;
         if (p1Valid_ff && p1Claim_ff && loaded_ff && !p1Write_ff && p1Ident_ff)
         begin
            cfgReadData_ff <= storeBus.rdData;
         end
         else
         begin
            cfgReadData_ff <= 32'h0000_0000;
         end
      end
   end

   assign cfgDone = cfgDone_ff;
   assign cfgRetry = cfgRetry_ff;
   assign cfgClaim = cfgClaim_ff;
   assign cfgReadData = cfgReadData_ff;
   assign loadDone = loaded_ff;
   assign eepromAbsent = absent_ff;

endmodule : subsystem_ident_eeprom_loader

// ==== ident_loader_pkg.sv ====
// Package of constants, types and helpers for the subsystem identity loader.
//
// Notes on behaviour
// - Subsystem identity comes from an external serial EEPROM as 96 bits that fill six 16-bit registers.
// - Each of the three functions holds a subsystem vendor register at 2Ch and a subsystem register at 2Eh.
// - Only the EEPROM load path and the default path write the identity registers; configuration writes leave them unchanged.
// - Loading starts as soon as reset is released.
// - With no EEPROM present, one common vendor default and a distinct subsystem default per function are loaded.
// - Only EEPROM bits 000h to 05Fh are used; the rest of the 1024-bit array is never read.
// - Bits arrive in 16-bit groups in order F0 vendor, F0 subsystem, F1, F2, first bit into register bit 15.
// - Function 0 is audio, function 1 the joystick and function 2 the UART.
// - Offsets 00h to 3Fh of each function form the standard header here; higher offsets are not claimed.
// - Claimed configuration accesses are answered with a retry while any identity register is still unloaded.
// - The device masters the two-wire bus, driving a 400 kHz serial clock and sampling serial data.
package ident_loader_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_FREQ_KHZ = 40000;
   localparam int SCL_FREQ_KHZ = 400;
   // A serial bit is four quarters; the rate is a maximum, so the quarter rounds up.
   localparam int QUARTER_INT = (CLK_FREQ_KHZ + 4 * SCL_FREQ_KHZ - 1) / (4 * SCL_FREQ_KHZ);
   localparam logic [4:0] QUARTER_LAST = 5'(QUARTER_INT - 1);

   // ----------------------------------------------------------------
   // Identity layout
   // ----------------------------------------------------------------
   localparam int WORD_BITS = 16;
   localparam int ID_BITS_INT = 96;
   localparam logic [6:0] ID_BITS = 7'h60;
   localparam logic [6:0] ID_LAST_BIT = 7'h5F;
   localparam int EEPROM_BITS = 1024;
   localparam logic [2:0] WORD_COUNT = 3'h6;
   localparam logic [2:0] WORD_LAST = 3'h5;
   localparam logic [1:0] FUNC_AUDIO = 2'h0;
   localparam logic [1:0] FUNC_JOYSTICK = 2'h1;
   localparam logic [1:0] FUNC_UART = 2'h2;
   localparam logic [1:0] FUNC_COUNT = 2'h3;

   // ----------------------------------------------------------------
   // Configuration header offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] CFG_SUBSYS_VENDOR_OFFSET = 8'h2C;
   localparam logic [7:0] CFG_SUBSYS_OFFSET = 8'h2E;
   localparam logic [7:0] CFG_HEADER_LAST = 8'h3F;

   // ----------------------------------------------------------------
   // Serial EEPROM commands
   // ----------------------------------------------------------------
   localparam logic [7:0] EE_CTRL_WRITE = 8'hA0;
   localparam logic [7:0] EE_CTRL_READ = 8'hA1;
   localparam logic [7:0] EE_START_ADDR = 8'h00;
   localparam logic [3:0] ACK_SLOT = 4'h8;

   // ----------------------------------------------------------------
   // Defaults when no EEPROM answers; the values are arbitrary.
   // ----------------------------------------------------------------
   localparam logic [15:0] DEFAULT_VENDOR = 16'hA5A5;
   localparam logic [15:0] DEFAULT_SUBSYS_AUDIO = 16'h0101;
   localparam logic [15:0] DEFAULT_SUBSYS_JOYSTICK = 16'h0102;
   localparam logic [15:0] DEFAULT_SUBSYS_UART = 16'h0103;

   // ----------------------------------------------------------------
   // Types and helpers
   // ----------------------------------------------------------------
   typedef enum logic [8:0]
   {
      ST_START1 = 9'h001,
      ST_CTRLW = 9'h002,
      ST_ADDR = 9'h004,
      ST_START2 = 9'h008,
      ST_CTRLR = 9'h010,
      ST_READ = 9'h020,
      ST_STOP = 9'h040,
      ST_DEFAULT = 9'h080,
      ST_DONE = 9'h100
   } load_state_t;

   // Word index of a function's vendor (sel 0) or subsystem (sel 1) register.
   function automatic logic [2:0] identIndex(input logic [1:0] func, input logic sel);
      identIndex = {func, sel};
   endfunction : identIndex

endpackage : ident_loader_pkg

// ==== ident_store_if.sv ====
// Interface between the loader and the identity word store.
`timescale 1ns/1ps
interface ident_store_if;
   logic wrEn;
   logic [2:0] wrIndex;
   logic [15:0] wrData;
   logic [1:0] rdFunc;
   logic [31:0] rdData;

   modport loader (output wrEn, output wrIndex, output wrData, output rdFunc, input rdData);
   modport store (input wrEn, input wrIndex, input wrData, input rdFunc, output rdData);
endinterface : ident_store_if

// ==== ident_store.sv ====
// Six-word store of the subsystem identity registers with a registered read port.
`timescale 1ns/1ps
module ident_store
(
   input wire logic clk,
   input wire logic rstN,
   ident_store_if.store bus
);
   import ident_loader_pkg::*;

   logic [15:0] words [6];
   logic [31:0] rdData_ff;

   // Only the load path has a write port, so configuration cycles cannot alter the words.
   always_ff @(posedge clk)
   begin
      if (bus.wrEn && bus.wrIndex <= WORD_LAST)
      begin
         words[bus.wrIndex] <= bus.wrData;
      end
   end

   // Read a whole dword: subsystem in the upper half, vendor in the lower half.
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         rdData_ff <= 32'h0000_0000;
      end
      else if (bus.rdFunc < FUNC_COUNT)
      begin
         rdData_ff <= {words[identIndex(bus.rdFunc, 1'b1)], words[identIndex(bus.rdFunc, 1'b0)]};
      end
      else
      begin
         rdData_ff <= 32'h0000_0000;
      end
   end

   assign bus.rdData = rdData_ff;

endmodule : ident_store

// ==== ident_loader_sva.sv ====
// Concurrent checks on the identity loader's top-level ports.
`timescale 1ns/1ps
module ident_loader_sva
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic cfgReq,
   input wire logic cfgWrite,
   input wire logic [1:0] cfgFunc,
   input wire logic [7:0] cfgOffset,
   input wire logic cfgDone,
   input wire logic cfgRetry,
   input wire logic cfgClaim,
   input wire logic [31:0] cfgReadData,
   input wire logic loadDone,
   input wire logic eepromAbsent,
   input wire logic configEepromClock,
   input wire logic configEepromSerialIn,
   input wire logic configEepromDataOut,
   input wire logic configEepromDataOe
);
   // ------
   // Helper
   // ------
   logic sclDly_ff;
   logic riseSeen_ff;
   logic [9:0] period_ff;
   wire logic sclRise = configEepromClock && !sclDly_ff;

   // Counts cycles between serial clock rises; the first rise after reset has no predecessor.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sclDly_ff <= 1'b1;
         riseSeen_ff <= 1'b0;
         period_ff <= 10'h000;
      end
      else
      begin
         sclDly_ff <= configEepromClock;
         riseSeen_ff <= riseSeen_ff || sclRise;
         period_ff <= sclRise ? 10'h000 : period_ff + 10'h001;
      end
   end

   // ----------
   // Assertions
   // ----------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   chk_done_cause: assert property (cfgDone |-> $past(cfgReq, 2))
      else $error("answer without a request two cycles before");
   chk_claim_decode: assert property (cfgDone |->
      cfgClaim == ($past(cfgFunc, 2) != 2'h3 && $past(cfgOffset, 2) <= 8'h3F))
      else $error("claim does not match function and offset");
   chk_retry_unloaded: assert property (cfgDone && cfgClaim && !loadDone |-> cfgRetry)
      else $error("claimed access answered before load without retry");
   chk_no_late_retry: assert property (cfgDone && $past(loadDone, 2) |-> !cfgRetry)
      else $error("retry after load finished");
   chk_refused_zero: assert property (cfgDone && (!cfgClaim || cfgRetry || $past(cfgWrite, 2))
      |-> cfgReadData == 32'h0)
      else $error("data returned on a refused or write access");
   chk_load_sticky: assert property (loadDone |=> loadDone)
      else $error("load done dropped without reset");
   chk_start_prompt: assert property ($rose(rst_b) |-> ##[1:40] !configEepromClock)
      else $error("serial transfer did not start after reset");
   chk_absent_load: assert property ($rose(eepromAbsent) |-> ##[0:300] loadDone)
      else $error("defaults not loaded after absence");
   chk_bit_period: assert property (sclRise && riseSeen_ff |-> period_ff == 10'h063)
      else $error("serial bit period is not 100 clocks");
   chk_idle_released: assert property (loadDone |-> configEepromClock && !configEepromDataOe)
      else $error("serial bus not idle after load");
   chk_open_drain: assert property (configEepromDataOe |-> !configEepromDataOut)
      else $error("data line driven high");
endmodule : ident_loader_sva

// ==== ident_eeprom_model.sv ====
// Behavioural two-wire serial EEPROM that answers the loader.
`timescale 1ns/1ps
module ident_eeprom_model
(
   input wire logic scl,
   input wire logic sda,
   output logic sdaLow
);
   logic present;
   logic reading;
   logic masterAck;
   logic [7:0] mem [0:127];
   logic [7:0] shift;
   logic [6:0] addr;
   int bitN;
   int byteN;

   initial
   begin
      sdaLow = 1'b0;
      present = 1'b1;
      reading = 1'b0;
      masterAck = 1'b0;
      bitN = 0;
      byteN = 0;
   end

   // Data falling with the clock high opens a frame; rising closes it.
   always @(sda)
   begin
      if (scl)
      begin
         bitN = 0;
         byteN = 0;
         sdaLow = 1'b0;
         if (sda)
            reading = 1'b0;
      end
   end

   // Bits are sampled on the clock rise; the ninth carries the master's acknowledge.
   always @(posedge scl)
   begin
      if (bitN < 8)
         shift = {shift[6:0], sda};
      else
         masterAck = !sda;
      bitN = bitN + 1;
   end

   // The line only changes while the clock is low, and a released line floats to the pull-up.
   always @(negedge scl)
   begin
      if (bitN == 8 && !reading)
      begin
         if (byteN == 0)
            reading = (shift == 8'hA1);
         else if (byteN == 1)
            addr = shift[6:0];
         sdaLow = present && (byteN > 0 || shift[7:1] == 7'h50);
         byteN = byteN + 1;
      end
      else if (bitN == 8)
      begin
         sdaLow = 1'b0;
         addr = addr + 7'h01;
      end
      else if (bitN == 9)
      begin
         bitN = 0;
         sdaLow = reading && masterAck && !mem[addr][7];
      end
      else if (reading && masterAck)
         sdaLow = !mem[addr][7 - bitN];
   end
endmodule : ident_eeprom_model

// ==== subsystem_ident_eeprom_loader_tb.sv ====
// Self-checking bench for the subsystem identity loader.
`timescale 1ns/1ps
module subsystem_ident_eeprom_loader_tb;
   import ident_loader_pkg::*;
   typedef struct {logic retry; logic claim; logic [31:0] data;} expect_t;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic cfgReq = 1'b0;
   logic cfgWrite = 1'b0;
   logic [1:0] cfgFunc = 2'h0;
   logic [7:0] cfgOffset = 8'h00;
   logic cfgDone, cfgRetry, cfgClaim, loadDone, eepromAbsent;
   logic configEepromClock, configEepromDataOut, configEepromDataOe, sdaLow;
   logic [31:0] cfgReadData;
   wire logic sdaLine;
   logic [15:0] words [0:5];
   logic loaded = 1'b0;
   expect_t expq [$];
   int error_cnt = 0;
   int checks = 0;
   int seed = 94;

   // Pull-up on the shared data line.
   assign sdaLine = !(configEepromDataOe || sdaLow);
   always #12.5 clk = ~clk;

   subsystem_ident_eeprom_loader uut (.clk(clk), .rst_b(rst_b), .cfgReq(cfgReq), .cfgWrite(cfgWrite),
      .cfgFunc(cfgFunc), .cfgOffset(cfgOffset), .cfgDone(cfgDone), .cfgRetry(cfgRetry),
      .cfgClaim(cfgClaim), .cfgReadData(cfgReadData), .loadDone(loadDone), .eepromAbsent(eepromAbsent),
      .configEepromClock(configEepromClock), .configEepromSerialIn(sdaLine),
      .configEepromDataOut(configEepromDataOut), .configEepromDataOe(configEepromDataOe));
   ident_eeprom_model ee (.scl(configEepromClock), .sda(sdaLine), .sdaLow(sdaLow));

   // ------
   // Tasks
   // ------
   task check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task end_sim;
      $display("Summary: %0d checks, %0d mismatches", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim

   // Issues one access and notes its answer; the strobe stays up for back-to-back calls.
   task access(input logic wr, input logic [1:0] f, input logic [7:0] off);
      expect_t e;
      @(negedge clk);
      cfgReq = 1'b1;
      cfgWrite = wr;
      cfgFunc = f;
      cfgOffset = off;
      e.claim = f != 2'h3 && off <= 8'h3F;
      e.retry = e.claim && !loaded;
      e.data = (e.claim && loaded && !wr && off[7:2] == 6'h0B) ? {words[2 * f + 1], words[2 * f]} : 32'h0;
      expq.push_back(e);
   endtask : access

   task idle;
      @(negedge clk);
      cfgReq = 1'b0;
      repeat (4) @(negedge clk);
   endtask : idle

   task resetDut;
      @(negedge clk);
      rst_b = 1'b0;
      loaded = 1'b0;
      repeat (10) @(negedge clk);
      check({28'h0, configEepromClock, loadDone, configEepromDataOe, configEepromDataOut}, 32'h8);
      rst_b = 1'b1;
      repeat (3) @(negedge clk);
   endtask : resetDut

   // A bounded wait, so a stuck loader ends the run instead of hanging it.
   task waitLoad;
      int n;
      n = 0;
      while (loadDone !== 1'b1 && n < 40000)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 40000)
      begin
         check({31'h0, loadDone}, 32'h1);
         end_sim();
      end
      loaded = 1'b1;
   endtask : waitLoad

   // Takes the oldest note off the queue at each answer; the falling edge sees the answer settled.
   always @(negedge clk)
   begin : monitor
      expect_t e;
      if (cfgDone === 1'b1)
      begin
         if (expq.size() == 0)
            check(32'h1, 32'h0);
         else
         begin
            e = expq.pop_front();
            check({30'h0, cfgRetry, cfgClaim}, {30'h0, e.retry, e.claim});
            check(cfgReadData, e.data);
         end
      end
   end

   // ------
   // Main
   // ------
   initial
   begin
      logic [31:0] r;
      for (int i = 0; i < 128; i++)
         ee.mem[i] = 8'($random(seed));
      for (int i = 0; i < 6; i++)
         words[i] = {ee.mem[2 * i], ee.mem[2 * i + 1]};
      resetDut();
      access(1'b0, 2'h0, 8'h2C);
      access(1'b1, 2'h1, 8'h2E);
      access(1'b0, 2'h3, 8'h2C);
      access(1'b0, 2'h2, 8'h40);
      idle();
      $display("test retry before load done");
      waitLoad();
      check({31'h0, eepromAbsent}, 32'h0);
      check({25'h0, ee.addr}, 32'h0000000C);
      for (int f = 0; f < 3; f++)
      begin
         access(1'b0, 2'(f), 8'h2C);
         access(1'b0, 2'(f), 8'h2E);
         access(1'b1, 2'(f), 8'h2C);
         access(1'b0, 2'(f), 8'h2F);
         access(1'b0, 2'(f), 8'h00);
      end
      repeat (24)
      begin
         r = $random(seed);
         access(r[8], r[10:9], {1'b0, r[6:0]});
      end
      idle();
      check(expq.size(), 32'h0);
      $display("test loaded identity done");
      ee.present = 1'b0;
      words = '{DEFAULT_VENDOR, DEFAULT_SUBSYS_AUDIO, DEFAULT_VENDOR, DEFAULT_SUBSYS_JOYSTICK,
         DEFAULT_VENDOR, DEFAULT_SUBSYS_UART};
      resetDut();
      access(1'b0, 2'h2, 8'h2C);
      idle();
      waitLoad();
      check({31'h0, eepromAbsent}, 32'h1);
      for (int f = 0; f < 3; f++)
         access(1'b0, 2'(f), 8'h2C);
      idle();
      check(expq.size(), 32'h0);
      $display("test absent defaults done");
      end_sim();
   end
endmodule : subsystem_ident_eeprom_loader_tb

bind subsystem_ident_eeprom_loader ident_loader_sva chk (.clk(clk), .rst_b(rst_b), .cfgReq(cfgReq),
   .cfgWrite(cfgWrite), .cfgFunc(cfgFunc), .cfgOffset(cfgOffset), .cfgDone(cfgDone), .cfgRetry(cfgRetry),
   .cfgClaim(cfgClaim), .cfgReadData(cfgReadData), .loadDone(loadDone), .eepromAbsent(eepromAbsent),
   .configEepromClock(configEepromClock), .configEepromSerialIn(configEepromSerialIn),
   .configEepromDataOut(configEepromDataOut), .configEepromDataOe(configEepromDataOe));
